// ### verilog/ser_map.vh
`ifndef SER_MAP_VH
`define SER_MAP_VH

// Register selectors on the query port
`define SER_SEL_MEAS 2'h0
`define SER_SEL_QUES 2'h1
`define SER_SEL_OPER 2'h2

// Query kinds
`define SER_KIND_EVENT 2'h0
`define SER_KIND_COND 2'h1
`define SER_KIND_ENAB 2'h2

// Measurement bit positions
`define SER_MEAS_ROF_BIT 0
`define SER_MEAS_LL1_BIT 1
`define SER_MEAS_HL1_BIT 2
`define SER_MEAS_LL2_BIT 3
`define SER_MEAS_HL2_BIT 4
`define SER_MEAS_RAV_BIT 5
`define SER_MEAS_BAV_BIT 7
`define SER_MEAS_BHF_BIT 8
`define SER_MEAS_BFL_BIT 9

// Questionable bit positions
`define SER_QUES_TEMP_BIT 4
`define SER_QUES_CAL_BIT 8
`define SER_QUES_WARN_BIT 14

// Operation bit positions
`define SER_OPER_MEAS_BIT 4
`define SER_OPER_TRIG_BIT 5
`define SER_OPER_IDLE_BIT 10

// Masks of implemented bits
`define SER_MEAS_USED 16'h03bf
`define SER_QUES_USED 16'h4110
`define SER_OPER_USED 16'h0430

// Reset values
`define SER_EVENT_RST 16'h0000
`define SER_ENAB_RST 16'h0000

// Trace buffer minimum fill for buffer_available
`define SER_BUF_AVAIL_MIN 2

`endif

// ### verilog/ser_event_reg.v
`timescale 1ns/1ps
`default_nettype none

`include "ser_map.vh"

// One latched event register with condition edge detect, enable mask and summary
module ser_event_reg #(
  parameter [15:0] USED_MASK = 16'hffff
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [15:0] cond_in,
  input wire [15:0] pulse_in,
  input wire read_clear_in,
  input wire enab_wr_in,
  input wire [15:0] enab_data_in,
  input wire preset_in,
  output wire [15:0] event_out,
  output wire [15:0] cond_out,
  output wire [15:0] enab_out,
  output wire summary_out
);

  reg [15:0] event_q;
  reg [15:0] event_d;
  reg [15:0] cond_q;
  reg [15:0] enab_q;
  wire [15:0] rise;

  // Rising edge of each condition plus one-shot events
  assign rise = ((cond_in & ~cond_q) | pulse_in) & USED_MASK;

  // Set wins over a read clear in the same cycle
  always @*
  begin
    event_d = event_q;
    if (read_clear_in)
      event_d = `SER_EVENT_RST;
    event_d = event_d | rise;
  end

  // Event, condition copy and enable mask storage
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      event_q <= `SER_EVENT_RST;
      cond_q <= 16'h0000;
      enab_q <= `SER_ENAB_RST;
    end
    else
    begin
      event_q <= event_d;
      cond_q <= cond_in & USED_MASK;
      if (preset_in)
        enab_q <= `SER_ENAB_RST;
      else if (enab_wr_in)
        enab_q <= enab_data_in & USED_MASK;
    end
  end

  assign event_out = event_q;
  assign cond_out = cond_in & USED_MASK;
  assign enab_out = enab_q;
  assign summary_out = |(event_q & enab_q);

endmodule

`default_nettype wire

// ### verilog/ser_status_regs.v
`timescale 1ns/1ps
`default_nettype none

`include "ser_map.vh"

// Operation
// - Three event registers, measurement, operation, questionable, each read by own query.
// - A read returns the register value whose bits show set events.
// - Reading an event register clears all its bits; a bit that sets in the same cycle as the read stays set.
// - Measurement bit 0 sets when a reading overflows the range.
// - Measurement bits 1 and 2 set on first low and high limit fails.
// - Measurement bits 3 and 4 set on second low and high limit fails.
// - Measurement bit 5 sets when a reading is taken and processed.
// - Measurement bit 7 sets when trace buffer holds at least two readings.
// - Measurement bit 8 sets when trace buffer reaches half capacity.
// - Measurement bit 9 sets when trace buffer is full.
// - Measurement bit 6 and bits 10 to 15 are unused.
// - Questionable bit 4 sets on invalid reference junction during thermocouple use.
// - Questionable bit 8 flags bad calibration constant until successful calibration.
// - Questionable bit 14 sets when a measurement command parameter is ignored.
// - Fault lamp on while any questionable event is set, off when cleared.
// - Operation bit 4 set while a measurement is performed.
// - Operation bit 5 set while in the device-action trigger stage.
// - Operation bit 10 set while the instrument is idle.
// - Each event register has an enable mask gating its summary bit.
// - Each register has a live, non-latching condition register.
module ser_status_regs #(
  parameter BUF_DEPTH_W = 10
) (
  input wire ref_clk_in,
  input wire rst_in,
  // Instrument condition inputs
  input wire reading_done_in,
  input wire reading_overflow_in,
  input wire low_limit_one_fail_in,
  input wire high_limit_one_fail_in,
  input wire low_limit_two_fail_in,
  input wire high_limit_two_fail_in,
  input wire [BUF_DEPTH_W:0] buf_count_in,
  input wire [BUF_DEPTH_W:0] buf_capacity_in,
  input wire ref_junction_invalid_in,
  input wire cal_constant_bad_in,
  input wire cal_success_in,
  input wire ignored_parameter_in,
  input wire acquiring_in,
  input wire device_action_in,
  input wire idle_in,
  // Query port from the command parser
  input wire query_valid_in,
  input wire [1:0] query_sel_in,
  input wire [1:0] query_kind_in,
  input wire enab_wr_in,
  input wire [1:0] enab_sel_in,
  input wire [15:0] enab_data_in,
  input wire preset_in,
  output wire query_ready_out,
  output reg resp_valid_out,
  output reg [15:0] resp_data_out,
  output wire [2:0] summary_out,
  output wire fault_lamp_out
);

  // Decode of a register selector
  function sel_hit;
    input [1:0] sel;
    input [1:0] want;
    begin
      sel_hit = (sel == want);
    end
  endfunction

  reg cal_bad_q;
  reg cal_seen_q;
  reg [15:0] meas_pulse;
  reg [15:0] meas_cond;
  reg [15:0] ques_cond;
  reg [15:0] ques_pulse;
  reg [15:0] oper_cond;
  reg [15:0] resp_d;
  wire [15:0] meas_ev;
  wire [15:0] ques_ev;
  wire [15:0] oper_ev;
  wire [15:0] meas_cd;
  wire [15:0] ques_cd;
  wire [15:0] oper_cd;
  wire [15:0] meas_en;
  wire [15:0] ques_en;
  wire [15:0] oper_en;
  wire ev_read;
  wire [2:0] clr;
  wire [2:0] ewr;
  wire [BUF_DEPTH_W:0] half_cap;

  assign half_cap = buf_capacity_in >> 1;
  assign query_ready_out = 1'b1;
  assign ev_read = query_valid_in && (query_kind_in == `SER_KIND_EVENT);

  // Read-clear and enable-write strobes per register
  assign clr[0] = ev_read && sel_hit(query_sel_in, `SER_SEL_MEAS);
  assign clr[1] = ev_read && sel_hit(query_sel_in, `SER_SEL_QUES);
  assign clr[2] = ev_read && sel_hit(query_sel_in, `SER_SEL_OPER);
  assign ewr[0] = enab_wr_in && sel_hit(enab_sel_in, `SER_SEL_MEAS);
  assign ewr[1] = enab_wr_in && sel_hit(enab_sel_in, `SER_SEL_QUES);
  assign ewr[2] = enab_wr_in && sel_hit(enab_sel_in, `SER_SEL_OPER);

  // Calibration fault held from power-up detection until good calibration
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cal_bad_q <= 1'b0;
      cal_seen_q <= 1'b0;
    end
    else
    begin
      cal_seen_q <= 1'b1;
      if (cal_success_in)
        cal_bad_q <= 1'b0;
      else if (!cal_seen_q && cal_constant_bad_in)
        cal_bad_q <= 1'b1;
    end
  end

  // Measurement conditions and one-shot reading events
  always @*
  begin
    meas_cond = 16'h0000;
    meas_pulse = 16'h0000;
    meas_pulse[`SER_MEAS_ROF_BIT] = reading_done_in && reading_overflow_in;
    meas_pulse[`SER_MEAS_LL1_BIT] = reading_done_in && low_limit_one_fail_in;
    meas_pulse[`SER_MEAS_HL1_BIT] = reading_done_in && high_limit_one_fail_in;
    meas_pulse[`SER_MEAS_LL2_BIT] = reading_done_in && low_limit_two_fail_in;
    meas_pulse[`SER_MEAS_HL2_BIT] = reading_done_in && high_limit_two_fail_in;
    meas_pulse[`SER_MEAS_RAV_BIT] = reading_done_in;
    meas_cond[`SER_MEAS_ROF_BIT] = reading_overflow_in;
    meas_cond[`SER_MEAS_LL1_BIT] = low_limit_one_fail_in;
    meas_cond[`SER_MEAS_HL1_BIT] = high_limit_one_fail_in;
    meas_cond[`SER_MEAS_LL2_BIT] = low_limit_two_fail_in;
    meas_cond[`SER_MEAS_HL2_BIT] = high_limit_two_fail_in;
    meas_cond[`SER_MEAS_BAV_BIT] = (buf_count_in >= `SER_BUF_AVAIL_MIN);
    meas_cond[`SER_MEAS_BHF_BIT] = (buf_capacity_in != 0) && (buf_count_in >= half_cap);
    meas_cond[`SER_MEAS_BFL_BIT] = (buf_capacity_in != 0) && (buf_count_in >= buf_capacity_in);
  end

  // Questionable and operation conditions
  always @*
  begin
    ques_cond = 16'h0000;
    ques_pulse = 16'h0000;
    oper_cond = 16'h0000;
    ques_cond[`SER_QUES_TEMP_BIT] = ref_junction_invalid_in;
    ques_cond[`SER_QUES_CAL_BIT] = cal_bad_q;
    ques_pulse[`SER_QUES_WARN_BIT] = ignored_parameter_in;
    oper_cond[`SER_OPER_MEAS_BIT] = acquiring_in;
    oper_cond[`SER_OPER_TRIG_BIT] = device_action_in;
    oper_cond[`SER_OPER_IDLE_BIT] = idle_in;
  end

  // Measurement register set, unused bits masked off
  ser_event_reg #(
    .USED_MASK(`SER_MEAS_USED)
  ) u_meas (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .cond_in(meas_cond),
    .pulse_in(meas_pulse),
    .read_clear_in(clr[0]),
    .enab_wr_in(ewr[0]),
    .enab_data_in(enab_data_in),
    .preset_in(preset_in),
    .event_out(meas_ev),
    .cond_out(meas_cd),
    .enab_out(meas_en),
    .summary_out(summary_out[0])
  );

  // Questionable register set, bit 15 forced low
  ser_event_reg #(
    .USED_MASK(`SER_QUES_USED)
  ) u_ques (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .cond_in(ques_cond),
    .pulse_in(ques_pulse),
    .read_clear_in(clr[1]),
    .enab_wr_in(ewr[1]),
    .enab_data_in(enab_data_in),
    .preset_in(preset_in),
    .event_out(ques_ev),
    .cond_out(ques_cd),
    .enab_out(ques_en),
    .summary_out(summary_out[1])
  );

  // Operation register set, bit 15 forced low
  ser_event_reg #(
    .USED_MASK(`SER_OPER_USED)
  ) u_oper (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .cond_in(oper_cond),
    .pulse_in(16'h0000),
    .read_clear_in(clr[2]),
    .enab_wr_in(ewr[2]),
    .enab_data_in(enab_data_in),
    .preset_in(preset_in),
    .event_out(oper_ev),
    .cond_out(oper_cd),
    .enab_out(oper_en),
    .summary_out(summary_out[2])
  );

  // Lamp follows any latched questionable event
  assign fault_lamp_out = |ques_ev;

  // Response mux: binary value of selected register
  always @*
  begin
    resp_d = 16'h0000;
    case ({query_kind_in, query_sel_in})
      {`SER_KIND_EVENT, `SER_SEL_MEAS}: resp_d = meas_ev;
      {`SER_KIND_EVENT, `SER_SEL_QUES}: resp_d = ques_ev;
      {`SER_KIND_EVENT, `SER_SEL_OPER}: resp_d = oper_ev;
      {`SER_KIND_COND, `SER_SEL_MEAS}: resp_d = meas_cd;
      {`SER_KIND_COND, `SER_SEL_QUES}: resp_d = ques_cd;
      {`SER_KIND_COND, `SER_SEL_OPER}: resp_d = oper_cd;
      {`SER_KIND_ENAB, `SER_SEL_MEAS}: resp_d = meas_en;
      {`SER_KIND_ENAB, `SER_SEL_QUES}: resp_d = ques_en;
      {`SER_KIND_ENAB, `SER_SEL_OPER}: resp_d = oper_en;
      default: resp_d = 16'h0000;
    endcase
  end

  // Registered answer, one cycle after the query
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      resp_valid_out <= 1'b0;
      resp_data_out <= 16'h0000;
    end
    else
    begin
      resp_valid_out <= query_valid_in;
      if (query_valid_in)
        resp_data_out <= resp_d;
    end
  end

endmodule

`default_nettype wire

// ### testbench/ser_status_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ser_status_regs_asserts #(
  parameter BUF_DEPTH_W = 10
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic reading_done_in,
  input wire logic [BUF_DEPTH_W:0] buf_count_in,
  input wire logic [BUF_DEPTH_W:0] buf_capacity_in,
  input wire logic ignored_parameter_in,
  input wire logic acquiring_in,
  input wire logic device_action_in,
  input wire logic idle_in,
  input wire logic query_valid_in,
  input wire logic [1:0] query_sel_in,
  input wire logic [1:0] query_kind_in,
  input wire logic preset_in,
  input wire logic resp_valid_out,
  input wire logic [15:0] resp_data_out,
  input wire logic [2:0] summary_out,
  input wire logic fault_lamp_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Event read strobes per register
  wire rd_ev = query_valid_in && query_kind_in == 2'h0;
  wire rd_meas = rd_ev && query_sel_in == 2'h0;
  wire rd_ques = rd_ev && query_sel_in == 2'h1;
  wire rd_oper = rd_ev && query_sel_in == 2'h2;
  // Measurement read while no reading completes and the buffer count and capacity hold
  sequence s_calm;
    rd_meas && !reading_done_in && $stable(buf_count_in) && $stable(buf_capacity_in);
  endsequence
  chk_answer_next: assert property (query_valid_in |=> resp_valid_out)
    else $error("no answer after query");
  chk_read_clears: assert property (s_calm ##1 s_calm |=> resp_data_out == 16'h0)
    else $error("event register not cleared by read");
  chk_meas_unused: assert property (rd_meas |=> (resp_data_out & 16'hfc40) == 16'h0)
    else $error("unused measurement bit set");
  chk_ques_unused: assert property (rd_ques |=> (resp_data_out & 16'hbeef) == 16'h0)
    else $error("unused questionable bit set");
  chk_oper_unused: assert property (rd_oper |=> (resp_data_out & 16'hfbcf) == 16'h0)
    else $error("unused operation bit set");
  chk_reading_avail: assert property (reading_done_in ##1 rd_meas |=> resp_data_out[5])
    else $error("reading available not latched");
  chk_warn_latch: assert property (ignored_parameter_in ##1 rd_ques |=> resp_data_out[14])
    else $error("ignored parameter not latched");
  chk_lamp_on: assert property (ignored_parameter_in |=> fault_lamp_out)
    else $error("lamp off after questionable event");
  chk_oper_live: assert property (query_valid_in && query_sel_in == 2'h2 && query_kind_in == 2'h1 |=>
    resp_data_out == {5'h0, $past(idle_in), 4'h0, $past(device_action_in), $past(acquiring_in), 4'h0})
    else $error("operation condition not live");
  chk_preset_quiet: assert property (preset_in |=> summary_out == 3'h0)
    else $error("summary set after preset");
  // Main scenarios seen
  cov_event_read: cover property (rd_ev);
  cov_lamp: cover property ($rose(fault_lamp_out));
  cov_summary: cover property (|summary_out);
endmodule
bind ser_status_regs ser_status_regs_asserts #(.BUF_DEPTH_W(BUF_DEPTH_W)) chk (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .reading_done_in(reading_done_in), .buf_count_in(buf_count_in),
  .buf_capacity_in(buf_capacity_in), .ignored_parameter_in(ignored_parameter_in), .acquiring_in(acquiring_in),
  .device_action_in(device_action_in), .idle_in(idle_in), .query_valid_in(query_valid_in),
  .query_sel_in(query_sel_in), .query_kind_in(query_kind_in), .preset_in(preset_in),
  .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out), .summary_out(summary_out),
  .fault_lamp_out(fault_lamp_out));
`default_nettype wire

// ### testbench/ser_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
  input wire logic ref_clk_in,
  input wire logic resp_valid_in,
  input wire logic [15:0] resp_data_in,
  output logic query_valid_out,
  output logic [1:0] query_sel_out,
  output logic [1:0] query_kind_out
);
  // Idle host selects nothing
  initial
  begin
    query_valid_out = 1'b0;
    query_sel_out = 2'h3;
    query_kind_out = 2'h3;
  end
  // Issue n back-to-back queries from a falling edge, return the last answer
  // Answer stands one cycle, so take it at the falling edge after the last query
  task ask(input [1:0] s, input [1:0] k, input integer n, output [15:0] d);
    begin
      query_sel_out = s;
      query_kind_out = k;
      query_valid_out = 1'b1;
      repeat (n) @(negedge ref_clk_in);
      d = resp_valid_in ? resp_data_in : 16'hxxxx;
      query_valid_out = 1'b0;
      query_sel_out = 2'h3;
      query_kind_out = 2'h3;
      @(negedge ref_clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_ser_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ser_status_regs;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg done = 1'b0, rj = 1'b0, calbad = 1'b1, calok = 1'b0, ign = 1'b0, ewr = 1'b0, pre = 1'b0;
  reg [4:0] lim = 5'h0, cnt = 5'h0, cap = 5'h08;
  reg [2:0] ops = 3'h0;
  reg [1:0] esel = 2'h0;
  reg [15:0] edata = 16'h0, d, e;
  wire qv, rv, lamp;
  wire [1:0] qs, qk;
  wire [15:0] rsp;
  wire [2:0] sum;
  integer errors = 0, tests_run = 0, i;
  // Block with an eight-deep trace buffer
  ser_status_regs #(.BUF_DEPTH_W(4)) uut (.ref_clk_in(clk), .rst_in(rst), .reading_done_in(done),
    .reading_overflow_in(lim[0]), .low_limit_one_fail_in(lim[1]), .high_limit_one_fail_in(lim[2]),
    .low_limit_two_fail_in(lim[3]), .high_limit_two_fail_in(lim[4]), .buf_count_in(cnt), .buf_capacity_in(cap),
    .ref_junction_invalid_in(rj), .cal_constant_bad_in(calbad), .cal_success_in(calok), .ignored_parameter_in(ign),
    .acquiring_in(ops[0]), .device_action_in(ops[1]), .idle_in(ops[2]), .query_valid_in(qv), .query_sel_in(qs),
    .query_kind_in(qk), .enab_wr_in(ewr), .enab_sel_in(esel), .enab_data_in(edata), .preset_in(pre),
    .query_ready_out(), .resp_valid_out(rv), .resp_data_out(rsp), .summary_out(sum), .fault_lamp_out(lamp));
  // Remote computer
  ser_host_model host (.ref_clk_in(clk), .resp_valid_in(rv), .resp_data_in(rsp), .query_valid_out(qv),
    .query_sel_out(qs), .query_kind_out(qk));
  // Clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  // Compare and count
  task chk(input [15:0] x, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== x)
      begin
        errors = errors + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
      end
    end
  endtask
  // One query and compare
  task ask1(input [1:0] s, input [1:0] k, input [15:0] x);
    begin
      host.ask(s, k, 1, d);
      chk(x, d);
    end
  endtask
  // Enable mask write
  task wen(input [1:0] s, input [15:0] v);
    begin
      esel = s;
      edata = v;
      ewr = 1'b1;
      @(negedge clk);
      ewr = 1'b0;
    end
  endtask
  // Power-up state and calibration fault
  task t_power;
    begin
      ask1(2'h0, 2'h0, 16'h0);
      ask1(2'h2, 2'h0, 16'h0);
      ask1(2'h1, 2'h1, 16'h0100);
      chk(16'h1, {15'h0, lamp});
      ask1(2'h1, 2'h0, 16'h0100);
      chk(16'h0, {15'h0, lamp});
      calok = 1'b1;
      @(negedge clk);
      calok = 1'b0;
      ask1(2'h1, 2'h1, 16'h0);
      ask1(2'h3, 2'h0, 16'h0);
      ask1(2'h0, 2'h3, 16'h0);
    end
  endtask
  // Each limit flag with its reading
  task t_limits;
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        lim = 5'h1 << i;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        ask1(2'h0, 2'h0, 16'h0020 | (16'h1 << i));
        ask1(2'h0, 2'h0, 16'h0);
      end
      lim = 5'h0;
      host.ask(2'h0, 2'h0, 2, d);
      chk(16'h0, d);
    end
  endtask
  // Trace buffer fill levels
  task t_buffer;
    begin
      cnt = 5'h1;
      @(negedge clk);
      ask1(2'h0, 2'h0, 16'h0);
      for (i = 0; i < 3; i = i + 1)
      begin
        cnt = 5'h2 << i;
        @(negedge clk);
        ask1(2'h0, 2'h0, 16'h0080 << i);
      end
      ask1(2'h0, 2'h1, 16'h0380);
      cnt = 5'h0;
    end
  endtask
  // Questionable events and lamp
  task t_ques;
    begin
      ign = 1'b1;
      @(negedge clk);
      ign = 1'b0;
      chk(16'h1, {15'h0, lamp});
      ask1(2'h1, 2'h0, 16'h4000);
      chk(16'h0, {15'h0, lamp});
      rj = 1'b1;
      @(negedge clk);
      ask1(2'h1, 2'h0, 16'h0010);
      rj = 1'b0;
    end
  endtask
  // Operation states, live and latched
  task t_oper;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        ops = 3'h1 << i;
        e = (i == 2) ? 16'h0400 : 16'h0010 << i;
        @(negedge clk);
        ask1(2'h2, 2'h1, e);
        ops = 3'h0;
        ask1(2'h2, 2'h0, e);
      end
    end
  endtask
  // Enable masks, summary and preset
  task t_enable;
    begin
      wen(2'h0, 16'hffff);
      ask1(2'h0, 2'h2, 16'h03bf);
      wen(2'h2, 16'hffff);
      ask1(2'h2, 2'h2, 16'h0430);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      chk(16'h1, {13'h0, sum});
      pre = 1'b1;
      @(negedge clk);
      pre = 1'b0;
      chk(16'h0, {13'h0, sum});
      ask1(2'h0, 2'h2, 16'h0);
      ask1(2'h0, 2'h0, 16'h0020);
    end
  endtask
  // Verdict and end of run
  task conclude;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Hang guard
  initial
  begin
    #20000;
    errors = errors + 1;
    conclude;
  end
  // Reset then scenarios
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_power;
    t_limits;
    t_buffer;
    t_ques;
    t_oper;
    t_enable;
    conclude;
  end
endmodule
`default_nettype wire
